/* File: design/display_config_command_decoder.sv */
// Purpose: decode display and drive configuration commands from host bytes
// Assumes: one host byte per cycle at most, dc low marks an opcode byte
// Notes: other opcodes and unexpected parameter bytes are ignored here
`timescale 1ns/1ps
module display_config_command_decoder (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Host byte stream
  input wire logic host_valid,
  input wire logic host_dc,
  input wire logic [7:0] host_data,
  // Pixel width lookup
  input wire logic pix_valid,
  input wire logic [5:0] pix_level,
  output logic width_valid,
  output logic [7:0] gray_pulse_width,
  output logic precharge_en,
  output logic drive_en,
  // Configuration outputs
  output logic [7:0] display_offset,
  output logic [1:0] display_mode,
  output logic sleep_on,
  output logic booster_select,
  output logic precharge_internal,
  output logic [4:0] power_mode,
  output logic [3:0] reset_phase_len,
  output logic [3:0] precharge_phase_len,
  output logic [3:0] clock_divide_setting,
  output logic [3:0] osc_freq_level,
  output logic [7:0] precharge_level_a,
  output logic [7:0] precharge_level_b,
  output logic [7:0] precharge_level_c,
  output logic [2:0] precharge_to_common_high_voltage,
  output logic [6:0] common_high_voltage,
  output logic display_clock,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic {IDLE, PARAM} state_t;
  state_t state_reg;
  logic [7:0] op_reg;
  logic [5:0] left_reg;
  logic [5:0] index_reg;
  logic [5:0] lut_sel_reg;
  logic [7:0] sel_width;
  logic [7:0] pix_width;
  logic [5:0] shown_level;

  // Decoded byte kinds
  logic op_byte, par_byte;
  assign op_byte = host_valid && !host_dc;
  assign par_byte = host_valid && host_dc && (state_reg == PARAM);

  // Parameter count for each multi-byte opcode
  function automatic logic [5:0] param_count(input logic [7:0] op);
    case (op)
      disp_cfg_pkg::OP_OFFSET, disp_cfg_pkg::OP_MASTER, disp_cfg_pkg::OP_POWER,
      disp_cfg_pkg::OP_PHASE, disp_cfg_pkg::OP_CLOCK, disp_cfg_pkg::OP_COMMON_HIGH_VOLTAGE: begin
        param_count = 6'h01;
      end
      disp_cfg_pkg::OP_GRAY_LUT: begin
        param_count = disp_cfg_pkg::LUT_BYTES;
      end
      disp_cfg_pkg::OP_PRECHARGE: begin
        param_count = disp_cfg_pkg::PRECHARGE_BYTES;
      end
      default: begin
        param_count = 6'h00;
      end
    endcase
  endfunction

  // Command sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= IDLE;
      op_reg <= 8'h00;
      left_reg <= 6'h00;
      index_reg <= 6'h00;
    end else if (op_byte) begin
      // A new opcode abandons any unfinished parameter run
      op_reg <= host_data;
      left_reg <= param_count(host_data);
      index_reg <= 6'h00;
      state_reg <= (param_count(host_data) != 6'h00) ? PARAM : IDLE;
    end else if (par_byte) begin
      left_reg <= left_reg - 6'h01;
      index_reg <= index_reg + 6'h01;
      if (left_reg == 6'h01) begin
        state_reg <= IDLE;
      end
    end
  end

  // Single-byte display mode and sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      display_mode <= disp_cfg_pkg::MODE_NORMAL;
      sleep_on <= 1'b1;
    end else if (op_byte) begin
      if (host_data[7:2] == disp_cfg_pkg::OP_MODE_BASE[7:2]) begin
        display_mode <= host_data[1:0];
      end
      if (host_data == disp_cfg_pkg::OP_SLEEP_ON) begin
        sleep_on <= 1'b1;
      end else if (host_data == disp_cfg_pkg::OP_SLEEP_OFF) begin
        sleep_on <= 1'b0;
      end
    end
  end

  // Single parameter commands, defined fields only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      display_offset <= disp_cfg_pkg::RST_OFFSET;
      booster_select <= 1'b1;
      precharge_internal <= 1'b1;
      power_mode <= disp_cfg_pkg::RST_POWER;
      reset_phase_len <= disp_cfg_pkg::RST_RESET_PHASE;
      precharge_phase_len <= disp_cfg_pkg::RST_PRECHG_PHASE;
      clock_divide_setting <= disp_cfg_pkg::RST_DIVIDE;
      osc_freq_level <= disp_cfg_pkg::RST_OSC;
      common_high_voltage <= disp_cfg_pkg::RST_COMMON_HIGH_VOLTAGE;
    end else if (par_byte) begin
      case (op_reg)
        disp_cfg_pkg::OP_OFFSET: begin
          display_offset <= host_data;
        end
        disp_cfg_pkg::OP_MASTER: begin
          booster_select <= host_data[disp_cfg_pkg::MASTER_SUPPLY_BIT];
          precharge_internal <= host_data[disp_cfg_pkg::MASTER_PRECHG_BIT];
        end
        disp_cfg_pkg::OP_POWER: begin
          power_mode <= host_data[4:0];
        end
        disp_cfg_pkg::OP_PHASE: begin
          reset_phase_len <= host_data[3:0];
          precharge_phase_len <= host_data[7:4];
        end
        disp_cfg_pkg::OP_CLOCK: begin
          clock_divide_setting <= host_data[3:0];
          osc_freq_level <= host_data[7:4];
        end
        disp_cfg_pkg::OP_COMMON_HIGH_VOLTAGE: begin
          common_high_voltage <= host_data[6:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Pre-charge levels of the three colours
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      precharge_level_a <= disp_cfg_pkg::RST_PRECHG_LEVEL;
      precharge_level_b <= disp_cfg_pkg::RST_PRECHG_LEVEL;
      precharge_level_c <= disp_cfg_pkg::RST_PRECHG_LEVEL;
    end else if (par_byte && op_reg == disp_cfg_pkg::OP_PRECHARGE) begin
      case (index_reg[1:0])
        2'h0: begin
          precharge_level_a <= host_data;
        end
        2'h1: begin
          precharge_level_b <= host_data;
        end
        default: begin
          precharge_level_c <= host_data;
        end
      endcase
    end
  end

  assign precharge_to_common_high_voltage = {precharge_level_c[disp_cfg_pkg::PRECHG_COMMON_HIGH_VOLTAGE_BIT],
                               precharge_level_b[disp_cfg_pkg::PRECHG_COMMON_HIGH_VOLTAGE_BIT],
                               precharge_level_a[disp_cfg_pkg::PRECHG_COMMON_HIGH_VOLTAGE_BIT]};

  // Gray width table, loaded by B8 and restored by B9
  logic lut_wr, lut_restore;
  assign lut_wr = par_byte && op_reg == disp_cfg_pkg::OP_GRAY_LUT;
  assign lut_restore = op_byte && host_data == disp_cfg_pkg::OP_LINEAR;

  gray_width_table u_table (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(lut_wr),
    .wr_idx(index_reg[4:0]),
    .wr_data(host_data),
    .restore(lut_restore),
    .pix_level(shown_level),
    .sel_level(lut_sel_reg),
    .pix_width(pix_width),
    .sel_width(sel_width)
  );

  display_clock_divider u_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .clock_divide_setting(clock_divide_setting),
    .display_clock(display_clock)
  );

  // Level actually shown after the display mode
  always_comb begin
    case (display_mode)
      disp_cfg_pkg::MODE_ALL_OFF: begin
        shown_level = 6'h00;
      end
      disp_cfg_pkg::MODE_ALL_ON: begin
        shown_level = disp_cfg_pkg::TOP_LEVEL;
      end
      disp_cfg_pkg::MODE_INVERSE: begin
        shown_level = disp_cfg_pkg::TOP_LEVEL - pix_level;
      end
      default: begin
        shown_level = pix_level;
      end
    endcase
  end

  // Registered pixel width result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      width_valid <= 1'b0;
      gray_pulse_width <= 8'h00;
      precharge_en <= 1'b0;
      drive_en <= 1'b0;
    end else begin
      width_valid <= pix_valid;
      gray_pulse_width <= pix_width;
      precharge_en <= pix_valid && shown_level != 6'h00;
      drive_en <= pix_valid && shown_level != 6'h00;
    end
  end

  // AXI4-Lite write side
  logic aw_held, w_held;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= disp_cfg_pkg::RESP_OKAY;
      lut_sel_reg <= 6'h00;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_reg[7:2] <= disp_cfg_pkg::ADDR_LUT_DATA[7:2])
                     ? disp_cfg_pkg::RESP_OKAY : disp_cfg_pkg::RESP_SLVERR;
      // Only the level select is writable
      if (aw_addr_reg[7:2] == disp_cfg_pkg::ADDR_LUT_SEL[7:2] && w_strb_reg[0]) begin
        lut_sel_reg <= w_data_reg[5:0];
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= disp_cfg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= disp_cfg_pkg::RESP_OKAY;
      case (s_axi_araddr[7:2])
        disp_cfg_pkg::ADDR_CFG_A[7:2]: begin
          s_axi_rdata <= {7'h00, power_mode, precharge_internal, booster_select,
                          sleep_on, 1'b0, display_mode, 6'h00, display_offset};
        end
        disp_cfg_pkg::ADDR_CFG_B[7:2]: begin
          s_axi_rdata <= {9'h000, common_high_voltage, osc_freq_level,
                          clock_divide_setting, precharge_phase_len, reset_phase_len};
        end
        disp_cfg_pkg::ADDR_PRECHG[7:2]: begin
          s_axi_rdata <= {8'h00, precharge_level_c, precharge_level_b, precharge_level_a};
        end
        disp_cfg_pkg::ADDR_STATUS[7:2]: begin
          s_axi_rdata <= {9'h000, (state_reg == PARAM), left_reg, 8'h00, op_reg};
        end
        disp_cfg_pkg::ADDR_LUT_SEL[7:2]: begin
          s_axi_rdata <= {26'h000_0000, lut_sel_reg};
        end
        disp_cfg_pkg::ADDR_LUT_DATA[7:2]: begin
          s_axi_rdata <= {24'h00_0000, sel_width};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= disp_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Offset byte lands after A2
  offset_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (par_byte && op_reg == disp_cfg_pkg::OP_OFFSET) |=> display_offset == $past(host_data))
    else $error("offset not loaded");
  // Mode follows opcode low bits
  mode_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_byte && host_data[7:2] == disp_cfg_pkg::OP_MODE_BASE[7:2])
      |=> display_mode == $past(host_data[1:0]))
    else $error("display mode not taken");
  // Inverse mode complements the level
  inverse_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    display_mode == disp_cfg_pkg::MODE_INVERSE |-> shown_level == 6'h3F - pix_level)
    else $error("inverse mapping wrong");
  // Master configuration bits
  master_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (par_byte && op_reg == disp_cfg_pkg::OP_MASTER)
      |=> booster_select == $past(host_data[0]) && precharge_internal == $past(host_data[2]))
    else $error("master configuration wrong");
  // Sleep turns off after AF
  sleep_ctrl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_byte && host_data == disp_cfg_pkg::OP_SLEEP_OFF) |=> !sleep_on)
    else $error("sleep not left");
  // Phase nibbles split correctly
  phase_split_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (par_byte && op_reg == disp_cfg_pkg::OP_PHASE)
      |=> reset_phase_len == $past(host_data[3:0]) && precharge_phase_len == $past(host_data[7:4]))
    else $error("phase lengths wrong");
  // Table load ends after 32 bytes
  lut_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lut_wr && left_reg == 6'h01 && !op_byte) |=> state_reg == IDLE)
    else $error("table load length wrong");
  // Level zero gives no drive
  zero_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pix_valid && shown_level == 6'h00) |=> !drive_en && !precharge_en && gray_pulse_width == 8'h00)
    else $error("level zero driven");
  // Common-high keeps seven bits
  common_high_voltage_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (par_byte && op_reg == disp_cfg_pkg::OP_COMMON_HIGH_VOLTAGE) |=> common_high_voltage == $past(host_data[6:0]))
    else $error("common-high level wrong");
endmodule

/* File: design/disp_cfg_pkg.sv */
// Purpose: shared constants for the display configuration command decoder
// Assumes: 8-bit host bytes, AXI4-Lite register readback with 32-bit data
// Notes: offsets, opcodes, master and pre-charge bit positions and the multi-bit reset values live here
package disp_cfg_pkg;
  // Opcodes handled by this block
  localparam logic [7:0] OP_OFFSET = 8'h00_A2;
  localparam logic [7:0] OP_MODE_BASE = 8'h00_A4;
  localparam logic [7:0] OP_MASTER = 8'h00_AD;
  localparam logic [7:0] OP_SLEEP_ON = 8'h00_AE;
  localparam logic [7:0] OP_SLEEP_OFF = 8'h00_AF;
  localparam logic [7:0] OP_POWER = 8'h00_B0;
  localparam logic [7:0] OP_PHASE = 8'h00_B1;
  localparam logic [7:0] OP_CLOCK = 8'h00_B3;
  localparam logic [7:0] OP_GRAY_LUT = 8'h00_B8;
  localparam logic [7:0] OP_LINEAR = 8'h00_B9;
  localparam logic [7:0] OP_PRECHARGE = 8'h00_BB;
  localparam logic [7:0] OP_COMMON_HIGH_VOLTAGE = 8'h00_BE;
  // Parameter byte counts
  localparam logic [5:0] LUT_BYTES = 6'h20;
  localparam logic [5:0] PRECHARGE_BYTES = 6'h03;
  // Display modes, low two opcode bits
  localparam logic [1:0] MODE_ALL_OFF = 2'h0;
  localparam logic [1:0] MODE_ALL_ON = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  localparam logic [1:0] MODE_INVERSE = 2'h3;
  // Field positions
  localparam int MASTER_SUPPLY_BIT = 0;
  localparam int MASTER_PRECHG_BIT = 2;
  localparam int PRECHG_COMMON_HIGH_VOLTAGE_BIT = 7;
  // Reset values, power mode codes and level and width limits
  localparam logic [7:0] RST_OFFSET = 8'h00_00;
  localparam logic [4:0] RST_POWER = 5'h00;
  localparam logic [4:0] POWER_SAVE_INT = 5'h12;
  localparam logic [4:0] POWER_EXT = 5'h05;
  localparam logic [4:0] POWER_SAVE_EXT = 5'h15;
  localparam logic [3:0] RST_RESET_PHASE = 4'h4;
  localparam logic [3:0] RST_PRECHG_PHASE = 4'h7;
  localparam logic [3:0] RST_DIVIDE = 4'h0;
  localparam logic [3:0] RST_OSC = 4'h9;
  localparam logic [7:0] RST_PRECHG_LEVEL = 8'h00_1C;
  localparam logic [6:0] RST_COMMON_HIGH_VOLTAGE = 7'h1F;
  localparam logic [7:0] RST_LUT_TOP = 8'h00_7B;
  localparam logic [7:0] MAX_WIDTH = 8'h00_7D;
  localparam logic [5:0] TOP_LEVEL = 6'h3F;
  // Register byte addresses
  localparam logic [7:0] ADDR_CFG_A = 8'h00_00;
  localparam logic [7:0] ADDR_CFG_B = 8'h00_04;
  localparam logic [7:0] ADDR_PRECHG = 8'h00_08;
  localparam logic [7:0] ADDR_STATUS = 8'h00_0C;
  localparam logic [7:0] ADDR_LUT_SEL = 8'h00_10;
  localparam logic [7:0] ADDR_LUT_DATA = 8'h00_14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: design/gray_width_table.sv */
// Purpose: odd-level pulse width table with derived even levels
// Assumes: one write or one restore per cycle at most
// Notes: lookups clamp every width to the maximum drive width
`timescale 1ns/1ps
module gray_width_table (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Table update
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic restore,
  // Lookups
  input wire logic [5:0] pix_level,
  input wire logic [5:0] sel_level,
  output logic [7:0] pix_width,
  output logic [7:0] sel_width
);
  logic [7:0] odd_reg [32];

  // Width of one gray level from the odd entries
  function automatic logic [7:0] level_width(input logic [5:0] lvl,
                                             input logic [7:0] lo, input logic [7:0] hi);
    logic [8:0] sum;
    logic [7:0] w;
    sum = {1'b0, lo} + {1'b0, hi};
    if (lvl == 6'h00) begin
      w = 8'h00;
    end else if (lvl[0]) begin
      w = hi;
    end else begin
      w = sum[8:1];
    end
    level_width = (w > disp_cfg_pkg::MAX_WIDTH) ? disp_cfg_pkg::MAX_WIDTH : w;
  endfunction

  // Table storage, linear on restore and linear at reset except entry 31
  always_ff @(posedge aclk) begin
    if (!aresetn || restore) begin
      for (int i = 0; i < 32; i++) begin
        odd_reg[i] <= 8'((4 * i) + 1);
      end
      if (!aresetn) begin
        odd_reg[31] <= disp_cfg_pkg::RST_LUT_TOP;
      end
    end else if (wr_en) begin
      odd_reg[wr_idx] <= wr_data;
    end
  end

  // Neighbour entries for both lookups
  logic [4:0] pix_hi, pix_lo, sel_hi, sel_lo;
  assign pix_hi = pix_level[5:1];
  assign pix_lo = pix_level[5:1] - 5'd1;
  assign sel_hi = sel_level[5:1];
  assign sel_lo = sel_level[5:1] - 5'd1;
  assign pix_width = level_width(pix_level, odd_reg[pix_lo], odd_reg[pix_hi]);
  assign sel_width = level_width(sel_level, odd_reg[sel_lo], odd_reg[sel_hi]);

  width_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pix_width <= disp_cfg_pkg::MAX_WIDTH)
    else $error("pulse width above maximum");
endmodule

/* File: design/display_clock_divider.sv */
// Purpose: front clock divider giving the display clock enable
// Assumes: divide setting may change at any time
// Notes: new setting applies at once, compared against the running count
`timescale 1ns/1ps
module display_clock_divider (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Setting and enable out
  input wire logic [3:0] clock_divide_setting,
  output logic display_clock
);
  logic [3:0] count_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 4'h0;
    end else if (count_reg >= clock_divide_setting) begin
      count_reg <= 4'h0;
    end else begin
      count_reg <= count_reg + 4'h1;
    end
  end

  assign display_clock = aresetn && (count_reg >= clock_divide_setting);

  // Gap between enables equals setting plus one
  divide_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (display_clock && clock_divide_setting == 4'h1 && $stable(clock_divide_setting))
      |=> !display_clock ##1 display_clock)
    else $error("display clock gap wrong");
endmodule

/* File: sim/host_byte_model.sv */
// Purpose: host model sending opcode and parameter bytes
// Assumes: one byte per clock, driven after the rising edge
// Notes: data line shows the inverted last byte while idle
`timescale 1ns/1ps
module host_byte_model (
  // Clock
  input wire logic aclk,
  // Byte stream
  output logic host_valid,
  output logic host_dc,
  output logic [7:0] host_data
);
  initial begin
    host_valid = 1'h0;
    host_dc = 1'h0;
    host_data = 8'h00;
  end
  task put(input logic dc, input logic [7:0] d);
    @(posedge aclk);
    host_valid <= 1'h1;
    host_dc <= dc;
    host_data <= d;
  endtask
  // Release stream, scramble stale data
  task idle;
    @(posedge aclk);
    host_valid <= 1'h0;
    host_data <= ~host_data;
  endtask
endmodule

/* File: sim/display_config_command_decoder_tb.sv */
// Purpose: self-checking bench for the command decoder
// Assumes: host model feeds bytes, bench drives lookups and register bus
// Notes: expected values follow the command formats
`timescale 1ns/1ps
module display_config_command_decoder_tb;
  logic aclk = 1'h0, aresetn = 1'h0, pix_valid = 1'h0, host_valid, host_dc, width_valid;
  logic precharge_en, drive_en, sleep_on, booster_select, precharge_internal, display_clock;
  logic [7:0] host_data, gray_pulse_width, display_offset, s_axi_awaddr = 8'h00;
  logic [7:0] precharge_level_a, precharge_level_b, precharge_level_c, s_axi_araddr = 8'h00;
  logic [5:0] pix_level = 6'h00;
  logic [4:0] power_mode;
  logic [3:0] reset_phase_len, precharge_phase_len, clock_divide_setting, osc_freq_level;
  logic [1:0] display_mode, s_axi_bresp, s_axi_rresp, rr;
  logic [2:0] precharge_to_common_high_voltage;
  logic [6:0] common_high_voltage;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, aw, w;
  logic [8:0] cmds [19] = '{9'h0AF, 9'h0B1, 9'h15A, 9'h0B3, 9'h1C2, 9'h0AD, 9'h1FA, 9'h0B0,
    9'h1F5, 9'h0BE, 9'h1FF, 9'h0A2, 9'h183, 9'h144, 9'h0BB, 9'h19F, 9'h11C, 9'h105, 9'h0AE};
  int fails = 0, tests_run = 0, n, k;
  display_config_command_decoder u_dut (.aclk, .aresetn, .host_valid, .host_dc, .host_data,
    .pix_valid, .pix_level, .width_valid, .gray_pulse_width, .precharge_en, .drive_en,
    .display_offset, .display_mode, .sleep_on, .booster_select, .precharge_internal,
    .power_mode, .reset_phase_len, .precharge_phase_len, .clock_divide_setting,
    .osc_freq_level, .precharge_level_a, .precharge_level_b, .precharge_level_c,
    .precharge_to_common_high_voltage, .common_high_voltage, .display_clock, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  host_byte_model u_host (.aclk, .host_valid, .host_dc, .host_data);
  // Clock at 25 ns
  always #12.5 aclk = ~aclk;
  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wait_ok;
    if (n >= 40) begin
      fails++;
      test_done;
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40 && (s_axi_awvalid || s_axi_wvalid); n++) begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (s_axi_bvalid) break;
    end
    wait_ok;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (s_axi_arready) break;
    end
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (s_axi_rvalid) break;
    end
    wait_ok;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask
  task pix(input logic [5:0] lv, input logic [7:0] wd, input logic en);
    @(posedge aclk);
    pix_valid <= 1'h1;
    pix_level <= lv;
    @(posedge aclk);
    pix_valid <= 1'h0;
    #1 chk("width", {width_valid, gray_pulse_width, precharge_en, drive_en}, {1'h1, wd, en, en});
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    #1 chk("cfg", {display_offset, display_mode, sleep_on, booster_select, precharge_internal,
      power_mode, precharge_level_c, common_high_voltage}, {8'h00, 2'h2, 3'h7, 5'h00, 8'h1C,
      7'h1F});
    chk("phase", {reset_phase_len, precharge_phase_len, clock_divide_setting, osc_freq_level},
      16'h4709);
    pix(6'h03, 8'h05, 1'h1);
    pix(6'h3F, 8'h7B, 1'h1);
    pix(6'h00, 8'h00, 1'h0);
    $display("test reset done");
    // back to back commands, fixed bits set
    foreach (cmds[i]) u_host.put(cmds[i][8], cmds[i][7:0]);
    u_host.idle;
    #1 chk("cmd", {reset_phase_len, precharge_phase_len, clock_divide_setting, osc_freq_level},
      16'hA52C);
    chk("cfg", {display_offset, sleep_on, booster_select, precharge_internal, power_mode,
      common_high_voltage}, {8'h83, 3'h4, 5'h15, 7'h7F});
    chk("prechg", {precharge_level_a, precharge_level_b, precharge_level_c, precharge_to_common_high_voltage},
      {24'h9F_1C05, 3'h1});
    k = 0;
    repeat (30) @(negedge aclk) k += display_clock;
    chk("clkdiv", k, 10);
    for (int m = 0; m < 4; m++) begin
      u_host.put(1'h0, 8'hA4 + 8'(m));
      u_host.idle;
      #1 chk("mode", display_mode, m[1:0]);
    end
    pix(6'h00, 8'h7B, 1'h1);
    pix(6'h3F, 8'h00, 1'h0);
    $display("test commands done");
    u_host.put(1'h0, 8'hA6);
    u_host.put(1'h0, 8'hB9);
    u_host.idle;
    pix(6'h3F, 8'h7D, 1'h1);
    pix(6'h02, 8'h03, 1'h1);
    u_host.put(1'h0, 8'hB8);
    for (int i = 0; i < 32; i++) u_host.put(1'h1, 8'(4 * i + 2));
    u_host.idle;
    pix(6'h3D, 8'h7A, 1'h1);
    pix(6'h3F, 8'h7D, 1'h1);
    pix(6'h02, 8'h04, 1'h1);
    axw(disp_cfg_pkg::ADDR_LUT_SEL, 32'h0000_0003);
    axr(disp_cfg_pkg::ADDR_LUT_DATA);
    chk("lut", {rr, rd}, {2'h0, 32'h0000_0006});
    axr(8'h20);
    chk("unmapped", {rr, rd}, {2'h2, 32'h0000_0000});
    $display("test table done");
    test_done;
  end
endmodule
